// ### core/tor_pkg.sv
// Shared constants and types of the timer option and interrupt register bank
package tor_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam int TOR_ADDR_W = 32;
	localparam int TOR_DATA_W = 32;
	localparam int TOR_NUM_TIMERS = 2;
	localparam logic [31:0] TOR_T1_PENDING_ADDR = 32'h4000_a800;
	localparam logic [31:0] TOR_T2_PENDING_ADDR = 32'h4000_a804;
	localparam logic [31:0] TOR_T1_MISSED_ADDR = 32'h4000_a818;
	localparam logic [31:0] TOR_T2_MISSED_ADDR = 32'h4000_a81c;
	localparam logic [31:0] TOR_T1_ENABLE_ADDR = 32'h4000_a840;
	localparam logic [31:0] TOR_T2_ENABLE_ADDR = 32'h4000_a844;
	localparam logic [31:0] TOR_T2_OPTION_ADDR = 32'h4000_f050;

	// ------------------------------------------------------------
	// Field positions and masks
	// ------------------------------------------------------------
	localparam int TOR_UPDATE_BIT = 0;
	localparam int TOR_CC_LSB = 1;
	localparam int TOR_TRIGGER_BIT = 6;
	localparam int TOR_MISS_SHIFT = 8;
	localparam logic [31:0] TOR_IRQ_MASK = 32'h0000_005f;
	localparam logic [31:0] TOR_CC_MASK = 32'h0000_001e;
	localparam logic [31:0] TOR_MISS_MASK = 32'h0000_1e00;
	localparam logic [31:0] TOR_ZERO_WORD = 32'h0000_0000;
	localparam logic [31:0] TOR_REG_RESET = 32'h0000_0000;

	// Option register fields
	localparam int TOR_OPT_W = 8;
	localparam int TOR_OPT_SEL_LSB = 0;
	localparam int TOR_OPT_GATE_BIT = 2;
	localparam int TOR_OPT_RSVD_BIT = 3;
	localparam int TOR_OPT_PINSEL_LSB = 4;
	localparam logic [7:0] TOR_OPT_RESET = 8'h00;

	// Trigger sources of external clock mode 2
	localparam logic [1:0] TOR_TRIG_PCLK = 2'h0;
	localparam logic [1:0] TOR_TRIG_CAL_1K = 2'h1;
	localparam logic [1:0] TOR_TRIG_REF_32K = 2'h2;
	localparam logic [1:0] TOR_TRIG_EXT_PIN = 2'h3;

	// Port A pin used by channels 1..4 when not moved to port B
	localparam logic [1:0] TOR_CH1_PA_PIN = 2'h0;
	localparam logic [1:0] TOR_CH2_PA_PIN = 2'h3;
	localparam logic [1:0] TOR_CH3_PA_PIN = 2'h1;
	localparam logic [1:0] TOR_CH4_PA_PIN = 2'h2;

	// Per-timer event pulses from the counter datapath
	typedef struct packed {
		logic trigger;
		logic [3:0] cc;
		logic update;
	} tor_evt_t;

	// Places an event set at its bit positions in the flag layout
	function automatic logic [31:0] tor_evt_bits(input tor_evt_t evt);
		logic [31:0] v;
		v = TOR_ZERO_WORD;
		v[TOR_UPDATE_BIT] = evt.update;
		v[TOR_CC_LSB +: 4] = evt.cc;
		v[TOR_TRIGGER_BIT] = evt.trigger;
		return v;
	endfunction : tor_evt_bits

endpackage : tor_pkg

// ### core/tor_irq_unit.sv
// Enable, pending and missed interrupt registers of one timer
`timescale 1ns/1ps
module tor_irq_unit
	import tor_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_enable_wr,
	input wire logic i_pending_wr,
	input wire logic i_missed_wr,
	input wire logic [31:0] i_wdata,
	input wire tor_evt_t i_evt,
	output logic [31:0] o_enable,
	output logic [31:0] o_pending,
	output logic [31:0] o_missed,
	output logic o_irq
);

	// ------------------------------------------------------------
	// Next values
	// ------------------------------------------------------------
	logic [31:0] evt_vec;
	logic [31:0] pend_clr;
	logic [31:0] miss_clr;
	logic [31:0] miss_set;
	logic [31:0] pending_next;
	logic [31:0] missed_next;

	// Write-one-to-clear; a fresh event beats the clear
	always_comb begin
		evt_vec = tor_evt_bits(i_evt);
		pend_clr = i_pending_wr ? i_wdata : TOR_ZERO_WORD;
		miss_clr = i_missed_wr ? i_wdata : TOR_ZERO_WORD;
		miss_set = (evt_vec & o_pending & TOR_CC_MASK) << TOR_MISS_SHIFT;
		pending_next = ((o_pending & ~pend_clr) | evt_vec) & TOR_IRQ_MASK;
		missed_next = ((o_missed & ~miss_clr) | miss_set) & TOR_MISS_MASK;
	end

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// Enables are plain read-write
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_enable <= TOR_REG_RESET;
		end else if (i_enable_wr) begin
			o_enable <= i_wdata & TOR_IRQ_MASK;
		end
	end

	// Sticky flags; reserved fields kept at zero
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pending <= TOR_REG_RESET;
			o_missed <= TOR_REG_RESET;
		end else begin
			o_pending <= pending_next;
			o_missed <= missed_next;
		end
	end

	// Request follows the stored flags, one cycle behind
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(o_pending & o_enable);
		end
	end

endmodule : tor_irq_unit

// ### core/tor_regs.sv
// Timer option and interrupt register bank with pin routing and trigger select
`timescale 1ns/1ps
//
// Overview of operation
// - Option bit 7 moves channel 4 to B4
// - Option bit 6 moves channel 3 to B3
// - Option bit 5 moves channel 2 to B2
// - Option bit 4 moves channel 1 to B1
// - Bit 2 ANDs external clock with mask
// - Bits 1:0 pick the mode 2 trigger
// - Enable bits: trigger 6, channels 4:1, update 0
// - Pending bits share the enable layout
// - Missed bits for channels at 12:9
// - Reserved read-only fields are undefined, ignored
// - Separate per-timer registers, all reset zero
//
module tor_regs
	import tor_pkg::*;
#(
	parameter int ADDR_W = TOR_ADDR_W,
	parameter int DATA_W = TOR_DATA_W
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	input wire tor_evt_t i_tim1_evt,
	input wire tor_evt_t i_tim2_evt,
	output logic o_tim1_irq,
	output logic o_tim2_irq,
	output logic o_irq,
	input wire logic [3:0] i_chan_out,
	input wire logic [3:0] i_chan_oe,
	output logic [3:0] o_chan_in,
	input wire logic [3:0] i_pa_in,
	output logic [3:0] o_pa_out,
	output logic [3:0] o_pa_oe,
	input wire logic [3:0] i_pb_in,
	output logic [3:0] o_pb_out,
	output logic [3:0] o_pb_oe,
	input wire logic i_cal_1khz,
	input wire logic i_ref_32khz,
	input wire logic i_ext_clock_pin,
	input wire logic i_ext_clock_mask_input,
	output logic o_trig_level,
	output logic o_trig_tick,
	output logic [7:0] o_option
);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// Full-word compare; any other address is unmapped
	function automatic logic tor_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [31:0] target
	);
		return addr == target[ADDR_W-1:0];
	endfunction : tor_hit

	logic hit_opt;
	logic [1:0] hit_pend;
	logic [1:0] hit_miss;
	logic [1:0] hit_en;

	// One hit line per register; timers never share one
	always_comb begin
		hit_opt = tor_hit(i_addr, TOR_T2_OPTION_ADDR);
		hit_pend[0] = tor_hit(i_addr, TOR_T1_PENDING_ADDR);
		hit_pend[1] = tor_hit(i_addr, TOR_T2_PENDING_ADDR);
		hit_miss[0] = tor_hit(i_addr, TOR_T1_MISSED_ADDR);
		hit_miss[1] = tor_hit(i_addr, TOR_T2_MISSED_ADDR);
		hit_en[0] = tor_hit(i_addr, TOR_T1_ENABLE_ADDR);
		hit_en[1] = tor_hit(i_addr, TOR_T2_ENABLE_ADDR);
	end

	// ------------------------------------------------------------
	// Option register
	// ------------------------------------------------------------
	logic [7:0] option_reg;

	// Reserved bit 3 is stored as written; software keeps it zero
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			option_reg <= TOR_OPT_RESET;
		end else if (i_wr && hit_opt) begin
			option_reg <= i_wdata[TOR_OPT_W-1:0];
		end
	end

	logic [3:0] pin_sel_b;
	logic gate_en;
	logic [1:0] trig_sel;

	// Field extraction
	assign pin_sel_b = option_reg[TOR_OPT_PINSEL_LSB +: 4];
	assign gate_en = option_reg[TOR_OPT_GATE_BIT];
	assign trig_sel = option_reg[TOR_OPT_SEL_LSB +: 2];

	// ------------------------------------------------------------
	// Interrupt banks, one per timer
	// ------------------------------------------------------------
	tor_evt_t evt [TOR_NUM_TIMERS];
	logic [31:0] enable_q [TOR_NUM_TIMERS];
	logic [31:0] pending_q [TOR_NUM_TIMERS];
	logic [31:0] missed_q [TOR_NUM_TIMERS];
	logic [TOR_NUM_TIMERS-1:0] irq_q;

	assign evt[0] = i_tim1_evt;
	assign evt[1] = i_tim2_evt;

	// Same bank twice; only the decode and the event input differ
	for (genvar t = 0; t < TOR_NUM_TIMERS; t++) begin : g_tim
		tor_irq_unit u_irq (
			.i_ref_clk(i_ref_clk),
			.i_rst(i_rst),
			.i_enable_wr(i_wr && hit_en[t]),
			.i_pending_wr(i_wr && hit_pend[t]),
			.i_missed_wr(i_wr && hit_miss[t]),
			.i_wdata(i_wdata[31:0]),
			.i_evt(evt[t]),
			.o_enable(enable_q[t]),
			.o_pending(pending_q[t]),
			.o_missed(missed_q[t]),
			.o_irq(irq_q[t])
		);
	end

	// Per-timer requests come straight from the bank flops
	assign o_tim1_irq = irq_q[0];
	assign o_tim2_irq = irq_q[1];

	// Combined request, registered once more
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |irq_q;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [31:0] rd_mux;

	// Unmapped addresses read zero; upper option bits read zero
	always_comb begin
		rd_mux = TOR_ZERO_WORD;
		if (hit_opt) begin
			rd_mux[TOR_OPT_W-1:0] = option_reg;
		end
		for (int t = 0; t < TOR_NUM_TIMERS; t++) begin
			if (hit_en[t]) begin
				rd_mux = enable_q[t];
			end
			if (hit_pend[t]) begin
				rd_mux = pending_q[t];
			end
			if (hit_miss[t]) begin
				rd_mux = missed_q[t];
			end
		end
	end

	// Data valid only in the cycle after the strobe
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			o_rdata <= DATA_W'(rd_mux);
		end else begin
			o_rdata <= '0;
		end
	end

	// ------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------
	// Pins and slow clocks are asynchronous to the bank clock
	logic [3:0] pa_meta;
	logic [3:0] pa_sync;
	logic [3:0] pb_meta;
	logic [3:0] pb_sync;
	logic [3:0] src_meta;
	logic [3:0] src_sync;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			pa_meta <= 4'h0;
			pa_sync <= 4'h0;
			pb_meta <= 4'h0;
			pb_sync <= 4'h0;
			src_meta <= 4'h0;
			src_sync <= 4'h0;
		end else begin
			pa_meta <= i_pa_in;
			pa_sync <= pa_meta;
			pb_meta <= i_pb_in;
			pb_sync <= pb_meta;
			src_meta <= {i_ext_clock_mask_input, i_ext_clock_pin, i_ref_32khz, i_cal_1khz};
			src_sync <= src_meta;
		end
	end

	// ------------------------------------------------------------
	// Channel pin routing
	// ------------------------------------------------------------
	logic [1:0] pa_pin [4];
	logic [3:0] pa_out_next;
	logic [3:0] pa_oe_next;
	logic [3:0] pb_out_next;
	logic [3:0] pb_oe_next;
	logic [3:0] chan_in_next;

	assign pa_pin[0] = TOR_CH1_PA_PIN;
	assign pa_pin[1] = TOR_CH2_PA_PIN;
	assign pa_pin[2] = TOR_CH3_PA_PIN;
	assign pa_pin[3] = TOR_CH4_PA_PIN;

	// Each channel drives exactly one pin; the unused one is released
	always_comb begin
		pa_out_next = 4'h0;
		pa_oe_next = 4'h0;
		pb_out_next = 4'h0;
		pb_oe_next = 4'h0;
		chan_in_next = 4'h0;
		for (int c = 0; c < 4; c++) begin
			if (pin_sel_b[c]) begin
				pb_out_next[c] = i_chan_out[c];
				pb_oe_next[c] = i_chan_oe[c];
				chan_in_next[c] = pb_sync[c];
			end else begin
				pa_out_next[pa_pin[c]] = i_chan_out[c];
				pa_oe_next[pa_pin[c]] = i_chan_oe[c];
				chan_in_next[c] = pa_sync[pa_pin[c]];
			end
		end
	end

	// Registered so every pin output comes from a flop
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pa_out <= 4'h0;
			o_pa_oe <= 4'h0;
			o_pb_out <= 4'h0;
			o_pb_oe <= 4'h0;
			o_chan_in <= 4'h0;
		end else begin
			o_pa_out <= pa_out_next;
			o_pa_oe <= pa_oe_next;
			o_pb_out <= pb_out_next;
			o_pb_oe <= pb_oe_next;
			o_chan_in <= chan_in_next;
		end
	end

	// ------------------------------------------------------------
	// External trigger select
	// ------------------------------------------------------------
	logic ext_level;
	logic trig_level_next;
	logic trig_prev_reg;

	// Mask only matters when the pin is the source
	always_comb begin
		ext_level = src_sync[2];
		if (gate_en) begin
			ext_level = src_sync[2] & src_sync[3];
		end
		case (trig_sel)
			TOR_TRIG_PCLK: trig_level_next = 1'b1;
			TOR_TRIG_CAL_1K: trig_level_next = src_sync[0];
			TOR_TRIG_REF_32K: trig_level_next = src_sync[1];
			TOR_TRIG_EXT_PIN: trig_level_next = ext_level;
			default: trig_level_next = 1'b0;
		endcase
	end

	// Peripheral clock ticks every cycle; others on rising edges
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			trig_prev_reg <= 1'b0;
			o_trig_level <= 1'b0;
			o_trig_tick <= 1'b0;
		end else begin
			trig_prev_reg <= trig_level_next;
			o_trig_level <= trig_level_next;
			if (trig_sel == TOR_TRIG_PCLK) begin
				o_trig_tick <= 1'b1;
			end else begin
				o_trig_tick <= trig_level_next & ~trig_prev_reg;
			end
		end
	end

	// Option value exported to the counter datapath
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_option <= TOR_OPT_RESET;
		end else begin
			o_option <= option_reg;
		end
	end

endmodule : tor_regs

// ### verification/tor_regs_properties.sv
// Concurrent checks of the timer option and interrupt register bank
`timescale 1ns/1ps
module tor_regs_checker
	import tor_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic o_tim1_irq,
	input wire logic o_tim2_irq,
	input wire logic o_irq,
	input wire logic [3:0] i_chan_out,
	input wire logic [3:0] i_chan_oe,
	input wire logic [3:0] o_pa_out,
	input wire logic [3:0] o_pa_oe,
	input wire logic [3:0] o_pb_out,
	input wire logic [3:0] o_pb_oe,
	input wire logic i_ext_clock_mask_input,
	input wire logic o_trig_level,
	input wire logic o_trig_tick,
	input wire logic [7:0] o_option
);
	// ------------------------------------------------------------
	// Bus and register checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == TOR_ZERO_WORD)
		else $error("read data not zero outside a read");
	AST_OPT_WRITE: assert property (i_wr && i_addr == TOR_T2_OPTION_ADDR
		|=> ##1 o_option == $past(i_wdata[7:0], 2)) else $error("option write lost");
	AST_OPT_READ: assert property (i_rd && i_addr == TOR_T2_OPTION_ADDR
		|=> o_rdata == {24'h0, $past(o_option)}) else $error("option readback wrong");
	AST_IRQ_MERGE: assert property (1'b1 |=> o_irq == $past(o_tim1_irq || o_tim2_irq))
		else $error("merged request wrong");

	// ------------------------------------------------------------
	// Pin routing moves in step with the exported option copy
	// ------------------------------------------------------------
	AST_CH1_ROUTE: assert property (1'b1 |=>
		o_pa_oe[0] == (!o_option[4] && $past(i_chan_oe[0]))
		&& o_pb_oe[0] == (o_option[4] && $past(i_chan_oe[0]))) else $error("ch1 route wrong");
	AST_CH2_ROUTE: assert property (1'b1 |=>
		o_pa_oe[3] == (!o_option[5] && $past(i_chan_oe[1]))
		&& o_pb_oe[1] == (o_option[5] && $past(i_chan_oe[1]))) else $error("ch2 route wrong");
	AST_CH3_ROUTE: assert property (1'b1 |=>
		o_pa_out[1] == (!o_option[6] && $past(i_chan_out[2]))
		&& o_pb_out[2] == (o_option[6] && $past(i_chan_out[2]))) else $error("ch3 route wrong");
	AST_CH4_ROUTE: assert property (1'b1 |=>
		o_pa_out[2] == (!o_option[7] && $past(i_chan_out[3]))
		&& o_pb_out[3] == (o_option[7] && $past(i_chan_out[3]))) else $error("ch4 route wrong");

	// ------------------------------------------------------------
	// Trigger selection
	// ------------------------------------------------------------
	AST_TRIG_PCLK: assert property (o_option[1:0] == TOR_TRIG_PCLK ##1
		o_option[1:0] == TOR_TRIG_PCLK |-> o_trig_tick) else $error("clock tick missing");
	AST_TICK_PULSE: assert property (o_trig_tick && $past(o_option[1:0]) != TOR_TRIG_PCLK
		&& o_option[1:0] != TOR_TRIG_PCLK |=> !o_trig_tick) else $error("tick too long");
	// Mask needs the two sync stages plus the output flop before it shows
	AST_CLOCK_GATE: assert property ((o_option[2:0] == 3'h7 && !i_ext_clock_mask_input)[*4]
		##1 o_option[2:0] == 3'h7 |-> !o_trig_level) else $error("masked trigger still high");

	CVR_IRQ: cover property (o_tim1_irq && o_irq);
	CVR_ALL_B: cover property (o_pb_oe == 4'hf);
	CVR_TICK: cover property (o_trig_tick && o_option[1:0] == TOR_TRIG_CAL_1K);
endmodule : tor_regs_checker

bind tor_regs tor_regs_checker tor_regs_checker_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_tim1_irq(o_tim1_irq), .o_tim2_irq(o_tim2_irq), .o_irq(o_irq),
	.i_chan_out(i_chan_out), .i_chan_oe(i_chan_oe), .o_pa_out(o_pa_out), .o_pa_oe(o_pa_oe),
	.o_pb_out(o_pb_out), .o_pb_oe(o_pb_oe), .i_ext_clock_mask_input(i_ext_clock_mask_input),
	.o_trig_level(o_trig_level), .o_trig_tick(o_trig_tick), .o_option(o_option));

// ### verification/test_tor_regs.sv
// Self-checking bench for the timer option and interrupt register bank
`timescale 1ns/1ps
module test_tor_regs;
	import tor_pkg::*;
	typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e;} tor_row_t;

	// ------------------------------------------------------------
	// Stimulus signals and the unit under test
	// ------------------------------------------------------------
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [31:0] i_addr = '0, i_wdata = '0, o_rdata;
	logic i_wr = 1'b0, i_rd = 1'b0, o_tim1_irq, o_tim2_irq, o_irq, o_trig_level, o_trig_tick;
	tor_evt_t i_tim1_evt = '0, i_tim2_evt = '0;
	logic [3:0] i_chan_out = 4'ha, i_chan_oe = 4'h0, i_pa_in = 4'h1, i_pb_in = 4'he;
	logic [3:0] o_chan_in, o_pa_out, o_pa_oe, o_pb_out, o_pb_oe;
	logic i_cal_1khz = 1'b1, i_ref_32khz = 1'b0, i_ext_clock_pin = 1'b1, i_mask = 1'b0;
	logic [7:0] o_option;
	int fail_count = 0, checks_done = 0, n;
	logic [31:0] regs_a[7] = '{TOR_T1_PENDING_ADDR, TOR_T2_PENDING_ADDR, TOR_T1_MISSED_ADDR,
		TOR_T2_MISSED_ADDR, TOR_T1_ENABLE_ADDR, TOR_T2_ENABLE_ADDR, TOR_T2_OPTION_ADDR};
	// Write row, then read back; last row is an unmapped hole
	tor_row_t rows[6] = '{'{TOR_T1_ENABLE_ADDR, 32'hffff_ffff, 32'h0000_005f},
		'{TOR_T2_ENABLE_ADDR, 32'h0000_0041, 32'h0000_0041},
		'{TOR_T2_OPTION_ADDR, 32'hffff_ff52, 32'h0000_0052},
		'{TOR_T1_PENDING_ADDR, 32'hffff_ffff, 32'h0000_0000},
		'{TOR_T2_MISSED_ADDR, 32'hffff_ffff, 32'h0000_0000},
		'{32'h4000_a808, 32'hffff_ffff, 32'h0000_0000}};
	// Option value and packed {pa_oe, pb_oe, pa_out, pb_out, chan_in}
	logic [7:0] r_opt[4] = '{8'h00, 8'hf0, 8'h50, 8'ha0};
	logic [19:0] r_exp[4] = '{20'hf0c01, 20'h0f0ae, 20'hc5c04, 20'h3a0ab};
	logic [7:0] t_opt[4] = '{8'h01, 8'h02, 8'h03, 8'h07};
	logic t_exp[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	tor_regs tor_regs_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_tim1_evt(i_tim1_evt), .i_tim2_evt(i_tim2_evt), .o_tim1_irq(o_tim1_irq),
		.o_tim2_irq(o_tim2_irq), .o_irq(o_irq), .i_chan_out(i_chan_out), .i_chan_oe(i_chan_oe),
		.o_chan_in(o_chan_in), .i_pa_in(i_pa_in), .o_pa_out(o_pa_out), .o_pa_oe(o_pa_oe),
		.i_pb_in(i_pb_in), .o_pb_out(o_pb_out), .o_pb_oe(o_pb_oe), .i_cal_1khz(i_cal_1khz),
		.i_ref_32khz(i_ref_32khz), .i_ext_clock_pin(i_ext_clock_pin),
		.i_ext_clock_mask_input(i_mask), .o_trig_level(o_trig_level),
		.o_trig_tick(o_trig_tick), .o_option(o_option));

	always #50 i_ref_clk = ~i_ref_clk;

	// ------------------------------------------------------------
	// Bus tasks and comparison
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 check(o_rdata, e);
	endtask : rdchk

	// Write option, then wait out the pin synchronisers
	task automatic opt(input logic [7:0] v);
		wr(TOR_T2_OPTION_ADDR, {24'h0, v});
		repeat (5) @(posedge i_ref_clk);
		#1;
	endtask : opt

	task automatic pulse(input logic t2, input tor_evt_t e);
		@(posedge i_ref_clk);
		if (t2) i_tim2_evt <= e;
		else i_tim1_evt <= e;
		@(posedge i_ref_clk);
		i_tim1_evt <= '0;
		i_tim2_evt <= '0;
		repeat (3) @(posedge i_ref_clk);
		#1;
	endtask : pulse

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		foreach (regs_a[k]) rdchk(regs_a[k], TOR_REG_RESET);
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].d);
			rdchk(rows[k].a, rows[k].e);
		end
		rdchk(TOR_T1_ENABLE_ADDR, 32'h0000_005f);
		i_chan_oe <= 4'hf;
		foreach (r_opt[k]) begin
			opt(r_opt[k]);
			check({12'h0, o_pa_oe, o_pb_oe, o_pa_out, o_pb_out, o_chan_in}, {12'h0, r_exp[k]});
		end
		foreach (t_opt[k]) begin
			opt(t_opt[k]);
			check({31'h0, o_trig_level}, {31'h0, t_exp[k]});
		end
		// Gated pin passes once the mask input is high
		i_mask <= 1'b1;
		opt(8'h07);
		check({31'h0, o_trig_level}, 32'h1);
		opt(8'h00);
		check({31'h0, o_trig_tick}, 32'h1);
		// One rising edge of the slow clock gives exactly one tick
		opt(8'h01);
		i_cal_1khz <= 1'b0;
		repeat (5) @(posedge i_ref_clk);
		i_cal_1khz <= 1'b1;
		n = 0;
		repeat (8) begin
			@(posedge i_ref_clk);
			#1 n += o_trig_tick;
		end
		check(n, 32'h1);
		pulse(1'b0, '{1'b0, 4'h1, 1'b0});
		rdchk(TOR_T1_PENDING_ADDR, 32'h0000_0002);
		pulse(1'b0, '{1'b0, 4'hf, 1'b0});
		rdchk(TOR_T1_MISSED_ADDR, 32'h0000_0200);
		pulse(1'b0, '{1'b1, 4'hf, 1'b1});
		rdchk(TOR_T1_MISSED_ADDR, 32'h0000_1e00);
		rdchk(TOR_T1_PENDING_ADDR, 32'h0000_005f);
		check({29'h0, o_tim1_irq, o_tim2_irq, o_irq}, 32'h5);
		wr(TOR_T1_PENDING_ADDR, 32'h0000_005f);
		wr(TOR_T1_MISSED_ADDR, 32'h0000_1e00);
		rdchk(TOR_T1_PENDING_ADDR, TOR_ZERO_WORD);
		rdchk(TOR_T1_MISSED_ADDR, TOR_ZERO_WORD);
		check({31'h0, o_irq}, 32'h0);
		// Channel 2 of timer 2 is not enabled, so no request yet
		pulse(1'b1, '{1'b0, 4'h2, 1'b0});
		rdchk(TOR_T2_PENDING_ADDR, 32'h0000_0004);
		check({30'h0, o_tim2_irq, o_irq}, 32'h0);
		pulse(1'b1, '{1'b0, 4'h0, 1'b1});
		check({30'h0, o_tim2_irq, o_irq}, 32'h3);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		rdchk(TOR_T2_OPTION_ADDR, TOR_REG_RESET);
		rdchk(TOR_T2_PENDING_ADDR, TOR_REG_RESET);
		results();
	end

	// Whole run is under two hundred cycles
	initial begin
		repeat (3000) @(posedge i_ref_clk);
		fail_count++;
		results();
	end
endmodule : test_tor_regs
